// file: acr_pkg.sv
package acr_pkg;
  // ------------------------------------------------------------
  // Register map (word offsets are byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] ACR_OFF_CTRL = 4'h0;
  localparam logic [3:0] ACR_OFF_RESULT = 4'h4;
  localparam logic [3:0] ACR_OFF_SAMPLE = 4'h8;
  localparam logic [3:0] ACR_OFF_IRQ_STAT = 4'hc;
  localparam logic [3:0] ACR_OFF_IRQ_MASK = 4'h8;
  localparam logic [3:0] ACR_OFF_DIV = 4'h0;
  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int ACR_BIT_FORMAT = 7;
  localparam int ACR_BIT_REF = 6;
  localparam int ACR_BIT_UNUSED = 5;
  localparam int ACR_CHAN_HI = 4;
  localparam int ACR_CHAN_LO = 2;
  localparam int ACR_BIT_GO = 1;
  localparam int ACR_BIT_POWER = 0;
  localparam logic [7:0] ACR_CTRL_RESET = 8'h00;
  // Every field but the spare bit 5 is stored, start/status included
  localparam logic [7:0] ACR_CTRL_WMASK = 8'hdf;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int ACR_CONV_PERIODS = 11;
  localparam int ACR_CLK_MHZ = 10;
  localparam int ACR_TAD_NS = 1600;
  localparam int ACR_TAD_CYCLES = (ACR_TAD_NS * ACR_CLK_MHZ + 999) / 1000;
  localparam int ACR_RES_W = 10;
  // Sequencer states
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_CONV = 2'b01
  } acr_state_t;
endpackage : acr_pkg

// file: acr_tick_div.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Conversion clock enable divider
// ------------------------------------------------------------
module acr_tick_div #(
  parameter int DIV = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstnSync,
  // Control
  input wire logic run,
  output logic tick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic tick_d;

  // Restart from zero whenever the sequencer is idle
  always_comb begin
    cnt_d = 16'h0000;
    tick_d = 1'b0;
    if (run) begin
      if (cnt_q == 16'(DIV - 1)) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= tick_d;
    end
  end
endmodule : acr_tick_div

// file: acr_adc_ctrl.sv
`timescale 1ns/10ps
module acr_adc_ctrl
  import acr_pkg::*;
#(
  parameter int TAD_CYCLES = acr_pkg::ACR_TAD_CYCLES,
  parameter int CONV_PERIODS = acr_pkg::ACR_CONV_PERIODS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic [1:0] avsResponse,
  // Analog front end
  input wire logic [9:0] sampleValue,
  output logic [2:0] channelSelect,
  output logic referenceSelect,
  output logic converterPowerOn,
  output logic sampleHold,
  // Interrupt
  output logic irq
);
  import acr_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rstSync1_q;
  logic rstnSync;

  // Two stage release so all logic leaves reset on the same edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_q <= 1'b0;
      rstnSync <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstnSync <= rstSync1_q;
    end
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [9:0] result_q;
  logic [9:0] result_d;
  logic stat_q;
  logic stat_d;
  logic mask_q;
  logic mask_d;
  acr_state_t state_q;
  acr_state_t state_d;
  logic [3:0] tadCnt_q;
  logic [3:0] tadCnt_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] resp_q;
  logic [1:0] resp_d;
  logic tick;
  logic reqValid;
  logic wrLane0;
  logic [31:0] rdMux;
  logic rdHit;
  logic done;
  logic [15:0] resultWord;

  assign reqValid = (avsRead || avsWrite) && !ack_q;
  assign wrLane0 = avsWrite && reqValid && avsByteenable[0];

  // ------------------------------------------------------------
  // Conversion clock enable
  // ------------------------------------------------------------
  acr_tick_div #(
    .DIV(TAD_CYCLES)
  ) uTick (
    .clk(ref_clk),
    .rstnSync(rstnSync),
    .run(state_q == ACR_CONV),
    .tick(tick)
  );

  // Completion on the last conversion clock period
  assign done = (state_q == ACR_CONV) && tick &&
                (tadCnt_q == 4'(CONV_PERIODS - 1));

  // ------------------------------------------------------------
  // Justified result view
  // ------------------------------------------------------------
  always_comb begin
    if (ctrl_q[ACR_BIT_FORMAT]) begin
      resultWord = {6'h00, result_q};
    end else begin
      resultWord = {result_q, 6'h00};
    end
  end

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    if (avsAddress == ACR_OFF_CTRL) begin
      rdMux = {24'h000000, ctrl_q};
    end else if (avsAddress == ACR_OFF_RESULT) begin
      rdMux = {16'h0000, resultWord};
    end else if (avsAddress == ACR_OFF_IRQ_MASK) begin
      rdMux = {31'h0000_0000, mask_q};
    end else if (avsAddress == ACR_OFF_IRQ_STAT) begin
      rdMux = {31'h0000_0000, stat_q};
    end else begin
      rdHit = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Control, sequencer and bus next state
  // ------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    result_d = result_q;
    stat_d = stat_q;
    mask_d = mask_q;
    state_d = state_q;
    tadCnt_d = tadCnt_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    resp_d = 2'b00;
    // One wait state: answer on the cycle after the request
    if (reqValid) begin
      ack_d = 1'b1;
      rdata_d = avsRead ? rdMux : 32'h0000_0000;
      resp_d = rdHit ? 2'b00 : 2'b10;
    end
    // Sequencer
    case (state_q)
      ACR_IDLE: begin
        tadCnt_d = 4'h0;
      end
      ACR_CONV: begin
        if (tick) begin
          tadCnt_d = tadCnt_q + 4'h1;
        end
        if (done) begin
          state_d = ACR_IDLE;
          ctrl_d[ACR_BIT_GO] = 1'b0;
          result_d = sampleValue;
          stat_d = 1'b1;
        end
      end
      default: begin
        state_d = ACR_IDLE;
      end
    endcase
    // Power off returns the sequencer to idle and clears start; a conversion cannot run unpowered
    if (!ctrl_q[ACR_BIT_POWER] && state_q == ACR_CONV) begin
      state_d = ACR_IDLE;
      ctrl_d[ACR_BIT_GO] = 1'b0;
      result_d = result_q;
      stat_d = stat_q;
    end
    // Software writes; bit 5 is never stored
    if (wrLane0 && avsAddress == ACR_OFF_CTRL) begin
      ctrl_d = (avsWritedata[7:0] & ACR_CTRL_WMASK);
      if (avsWritedata[ACR_BIT_GO] && avsWritedata[ACR_BIT_POWER]) begin
        if (state_q == ACR_IDLE || done) begin
          state_d = ACR_CONV;
          tadCnt_d = 4'h0;
        end
        // Rewrite of 1 while busy keeps the running conversion
      end else if (!avsWritedata[ACR_BIT_GO] && state_q == ACR_CONV) begin
        state_d = ACR_IDLE;
        result_d = result_q;
        stat_d = stat_q;
      end
      if (!avsWritedata[ACR_BIT_POWER]) begin
        ctrl_d[ACR_BIT_GO] = 1'b0;
        state_d = ACR_IDLE;
      end
    end else if (wrLane0 && avsAddress == ACR_OFF_IRQ_MASK) begin
      mask_d = avsWritedata[0];
    end else if (wrLane0 && avsAddress == ACR_OFF_IRQ_STAT) begin
      // A completion in this same cycle wins over the clear
      if (avsWritedata[0] && !done) begin
        stat_d = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      ctrl_q <= ACR_CTRL_RESET;
      result_q <= 10'h000;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      state_q <= ACR_IDLE;
      tadCnt_q <= 4'h0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'b00;
    end else begin
      ctrl_q <= ctrl_d;
      result_q <= result_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      state_q <= state_d;
      tadCnt_q <= tadCnt_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      channelSelect <= 3'h0;
      referenceSelect <= 1'b0;
      converterPowerOn <= 1'b0;
      sampleHold <= 1'b0;
      irq <= 1'b0;
      avsWaitrequest <= 1'b1;
    end else begin
      channelSelect <= ctrl_d[ACR_CHAN_HI:ACR_CHAN_LO];
      referenceSelect <= ctrl_d[ACR_BIT_REF];
      converterPowerOn <= ctrl_d[ACR_BIT_POWER];
      sampleHold <= (state_d == ACR_CONV);
      irq <= stat_d && mask_d;
      // Registered so the stall line comes straight from a flop
      avsWaitrequest <= !ack_d;
    end
  end

  assign avsReaddata = rdata_q;
  assign avsResponse = resp_q;
endmodule : acr_adc_ctrl

// file: acr_adc_ctrl_properties.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker for the converter control block
// ------------------------------------------------------------
module acr_adc_ctrl_properties #(
  parameter int TAD_CYCLES = 16
) (
  // Clock and reset
  input logic ref_clk,
  input logic rstn,
  // Register bus
  input logic avsRead,
  input logic avsWrite,
  input logic [3:0] avsAddress,
  input logic [31:0] avsReaddata,
  input logic avsWaitrequest,
  input logic [1:0] avsResponse,
  // Converter side
  input logic converterPowerOn,
  input logic sampleHold
);
  // Small margin over eleven periods for the registered start and stop
  localparam int ConvMax = 11 * TAD_CYCLES + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Request pending and its single-cycle answer
  sequence s_req;
    (avsRead || avsWrite) && avsWaitrequest;
  endsequence
  sequence s_ack;
    !avsWaitrequest;
  endsequence
  a_ack_follows_req: assert property (s_req |-> ##[1:2] s_ack)
    else $error("no answer to request");
  a_ack_one_cycle: assert property (s_ack |=> avsWaitrequest)
    else $error("answer longer than one cycle");
  a_ack_needs_req: assert property (s_ack |-> $past(avsRead || avsWrite))
    else $error("answer without request");
  a_resp_legal: assert property (s_ack |-> avsResponse == 2'b00 || avsResponse == 2'b10)
    else $error("bad response code");
  a_unmapped_zero: assert property (s_ack and avsResponse == 2'b10 |-> avsReaddata == 32'h0)
    else $error("unmapped read not zero");
  a_spare_bit_zero: assert property (
    s_ack and $past(avsRead) && $past(avsAddress) == 4'h0 |-> !avsReaddata[5])
    else $error("spare control bit reads one");
  a_hold_needs_power: assert property ($rose(sampleHold) |-> ##[0:1] converterPowerOn)
    else $error("conversion without power");
  a_off_stops_conv: assert property ($fell(converterPowerOn) |-> ##[0:2] !sampleHold)
    else $error("conversion survives power off");
  a_conv_bounded: assert property ($rose(sampleHold) |-> ##[1:ConvMax] !sampleHold)
    else $error("conversion too long");
endmodule : acr_adc_ctrl_properties

bind acr_adc_ctrl acr_adc_ctrl_properties #(.TAD_CYCLES(TAD_CYCLES)) acr_adc_ctrl_properties_inst (
  .ref_clk, .rstn, .avsRead, .avsWrite, .avsAddress, .avsReaddata, .avsWaitrequest,
  .avsResponse, .converterPowerOn, .sampleHold);

// file: acr_adc_ctrl_tb.sv
`timescale 1ns/10ps
module acr_adc_ctrl_tb;
  import acr_pkg::*;
  logic ref_clk, rstn, avsRead, avsWrite, avsWaitrequest, referenceSelect;
  logic converterPowerOn, sampleHold, irq;
  logic [3:0] avsAddress, avsByteenable;
  logic [31:0] avsWritedata, avsReaddata, q;
  logic [1:0] avsResponse, r;
  logic [9:0] sampleValue;
  logic [2:0] channelSelect;
  int badCount, checkCount, n;
  // Short conversion clock keeps each conversion at twelve cycles of sampleHold
  acr_adc_ctrl #(.TAD_CYCLES(1)) acr_adc_ctrl_inst (.ref_clk, .rstn, .avsAddress, .avsRead,
    .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest, .avsResponse,
    .sampleValue, .channelSelect, .referenceSelect, .converterPowerOn, .sampleHold, .irq);
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic completeRun;
    if (badCount == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : completeRun
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low, then releases
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsRead <= !w;
    avsWrite <= w;
    // Values read right after the edge are those the edge sampled
    do begin
      @(posedge ref_clk);
      k++;
    end while (avsWaitrequest !== 1'b0 && k < 50);
    chk(k < 50, 1);
    q = avsReaddata;
    r = avsResponse;
    avsRead <= 0;
    avsWrite <= 0;
    @(posedge ref_clk);
  endtask : bus
  task automatic conv(input logic [9:0] v, input logic [7:0] c);
    sampleValue <= v;
    bus(1, ACR_OFF_CTRL, {24'h0, c});
    chk(sampleHold, 1);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (sampleHold !== 1'b0 && n < 60);
    chk(n >= 6 && n <= 13, 1);
    repeat (3) @(posedge ref_clk);
  endtask : conv
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 0;
    avsRead = 0;
    avsWrite = 0;
    avsAddress = 0;
    avsWritedata = 0;
    avsByteenable = 4'hf;
    sampleValue = 0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    repeat (3) @(posedge ref_clk);
    bus(0, ACR_OFF_CTRL, 0);
    chk(q, 0);
    bus(1, ACR_OFF_CTRL, 32'he1);
    bus(0, ACR_OFF_CTRL, 0);
    chk(q, 32'hc1);
    chk({referenceSelect, converterPowerOn}, 2'b11);
    for (int c = 0; c < 8; c++) begin
      bus(1, ACR_OFF_CTRL, 32'hc1 | 32'(c << 2));
      chk(channelSelect, c[2:0]);
    end
    bus(1, ACR_OFF_IRQ_MASK, 1);
    conv(10'h2a5, 8'hdf);
    bus(0, ACR_OFF_CTRL, 0);
    chk(q, 32'hdd);
    chk(irq, 1);
    bus(0, ACR_OFF_RESULT, 0);
    chk(q, 32'h2a5);
    bus(1, ACR_OFF_IRQ_STAT, 1);
    chk(irq, 0);
    conv(10'h3c1, 8'h1f);
    bus(0, ACR_OFF_RESULT, 0);
    chk(q, 32'hf040);
    // Masked source must keep the line low while status stays set
    bus(1, ACR_OFF_IRQ_MASK, 0);
    chk(irq, 0);
    bus(0, ACR_OFF_IRQ_MASK, 0);
    chk(q, 0);
    bus(1, ACR_OFF_IRQ_STAT, 1);
    sampleValue <= 10'h155;
    bus(1, ACR_OFF_CTRL, 32'h1f);
    chk(sampleHold, 1);
    chk(referenceSelect, 0);
    bus(0, ACR_OFF_CTRL, 0);
    chk(q, 32'h1f);
    bus(1, ACR_OFF_CTRL, 32'h1d);
    repeat (15) @(posedge ref_clk);
    bus(0, ACR_OFF_IRQ_STAT, 0);
    chk(q, 0);
    bus(0, ACR_OFF_RESULT, 0);
    chk(q, 32'hf040);
    bus(1, ACR_OFF_CTRL, 0);
    chk(converterPowerOn, 0);
    bus(1, ACR_OFF_CTRL, 32'h02);
    bus(0, ACR_OFF_CTRL, 0);
    chk(q, 0);
    bus(0, 4'h2, 0);
    chk(r, 2'b10);
    chk(q, 0);
    completeRun();
  end
  // Watchdog well beyond the 150 or so cycles the tests need
  initial begin
    #300000;
    badCount++;
    completeRun();
  end
endmodule : acr_adc_ctrl_tb
